// file: rtl/kks_pkg.sv
// Package: constants and state type for the keypad and knob scanner
package kks_pkg;
    localparam int unsigned ROW_COUNT     = 3;
    localparam int unsigned COL_COUNT     = 3;
    localparam int unsigned SETTLE_CYCLES = 4;
    localparam int unsigned ANGLE_WIDTH   = 16;
    localparam logic [1:0]  KEY_NONE      = 2'h3;

    typedef enum logic [3:0] {
        ST_ARMED  = 4'h1,
        ST_DRIVE  = 4'h2,
        ST_PROBE  = 4'h4,
        ST_REPORT = 4'h8
    } kks_state_type;
endpackage

// file: rtl/kks_knob_decoder.sv
// Module: two-phase knob decoder with signed edge count
module kks_knob_decoder #(
    parameter int unsigned ANGLE_WIDTH = kks_pkg::ANGLE_WIDTH
) (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    // Encoder phases
    input  wire logic                          phase_a,
    input  wire logic                          phase_b,
    // Results
    output logic                               knob_edge,
    output logic                               knob_cw_reg,
    output logic signed [ANGLE_WIDTH-1:0]      angle_reg
);
    logic a_prev_reg;
    logic b_prev_reg;

    wire  edge_a     = phase_a ^ a_prev_reg;
    wire  edge_b     = phase_b ^ b_prev_reg;
    // Gray sequence: A edge with A!=B, or B edge with A==B, means clockwise
    wire  cw_now     = edge_a ? (phase_a != phase_b) : (phase_a == phase_b);
    wire  both_edges = edge_a & edge_b;

    // A simultaneous double edge is a skipped state; direction unknown, dropped
    assign knob_edge = (edge_a | edge_b) & ~both_edges;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            a_prev_reg  <= 1'b0;
            b_prev_reg  <= 1'b0;
            knob_cw_reg <= 1'b0;
            angle_reg   <= '0;
        end else begin
            a_prev_reg <= phase_a;
            b_prev_reg <= phase_b;
            if (knob_edge) begin
                knob_cw_reg <= cw_now;
                angle_reg   <= cw_now ? angle_reg + ANGLE_WIDTH'(1) : angle_reg - ANGLE_WIDTH'(1);
            end
        end
    end

    chk_angle_step: assert property (@(posedge ref_clk) disable iff (rst)
        knob_edge |=> (angle_reg - $past(angle_reg)) == (knob_cw_reg ? 1 : -1))
        else $error("angle did not step by one");
    chk_cw_direction: assert property (@(posedge ref_clk) disable iff (rst)
        (knob_edge && edge_a && phase_a != phase_b) |=> knob_cw_reg)
        else $error("clockwise edge not recognised");
    chk_angle_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !knob_edge |=> $stable(angle_reg))
        else $error("angle moved without an edge");
    cov_knob_cw: cover property (@(posedge ref_clk) disable iff (rst) knob_edge && cw_now);
    cov_knob_ccw: cover property (@(posedge ref_clk) disable iff (rst) knob_edge && !cw_now);
endmodule // kks_knob_decoder

// file: rtl/kks_scanner.sv
// Module: interrupt-driven 3x3 keypad scanner with knob front end
module kks_scanner #(
    parameter int unsigned ROW_COUNT     = kks_pkg::ROW_COUNT,
    parameter int unsigned COL_COUNT     = kks_pkg::COL_COUNT,
    parameter int unsigned SETTLE_CYCLES = kks_pkg::SETTLE_CYCLES,
    parameter int unsigned ANGLE_WIDTH   = kks_pkg::ANGLE_WIDTH
) (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    // Row lines, two-way: pulled low, key pulls row to driven column
    input  wire logic [ROW_COUNT-1:0]          row_in,
    output logic      [ROW_COUNT-1:0]          row_out,
    output logic      [ROW_COUNT-1:0]          row_oe,
    // Column lines, two-way
    input  wire logic [COL_COUNT-1:0]          col_in,
    output logic      [COL_COUNT-1:0]          col_out,
    output logic      [COL_COUNT-1:0]          col_oe,
    // Encoder phases
    input  wire logic                          phase_a,
    input  wire logic                          phase_b,
    // Interrupt and results
    output logic                               keypad_edge_interrupt,
    output logic                               key_valid,
    output logic      [1:0]                    key_row_reg,
    output logic      [1:0]                    key_col_reg,
    output logic                               knob_cw_reg,
    output logic signed [ANGLE_WIDTH-1:0]      angle_reg
);
    kks_pkg::kks_state_type state_reg;
    kks_pkg::kks_state_type state_next;
    logic [ROW_COUNT-1:0] row_prev_reg;
    logic [1:0]           row_sel_reg;
    logic [1:0]           col_idx_reg;
    logic [3:0]           settle_reg;
    logic                 key_valid_reg;
    logic                 knob_edge;

    // In idle all columns drive high so any press lifts its row
    wire                  armed     = (state_reg == kks_pkg::ST_ARMED);
    wire [ROW_COUNT-1:0]  row_rise  = row_in & ~row_prev_reg;
    wire                  row_event = armed & (|row_rise);
    wire                  settled   = (settle_reg == 4'(SETTLE_CYCLES - 1));
    wire                  last_col  = (col_idx_reg == 2'(COL_COUNT - 1));
    // Sense the high column while the found row drives
    wire                  col_hit   = col_in[col_idx_reg];

    // Lowest rising row wins when several rise together
    logic [1:0] first_row;
    always_comb begin
        first_row = 2'h0;
        for (int i = ROW_COUNT - 1; i >= 0; i--) begin
            if (row_rise[i]) begin
                first_row = 2'(i);
            end
        end
    end

    // Rows listen while armed; the found row is output high afterwards
    genvar g;
    generate
        for (g = 0; g < ROW_COUNT; g++) begin : g_row
            assign row_oe[g]  = !armed && (row_sel_reg == 2'(g));
            assign row_out[g] = 1'b1;
        end
        for (g = 0; g < COL_COUNT; g++) begin : g_col
            assign col_oe[g]  = armed;
            assign col_out[g] = 1'b1;
        end
    endgenerate

    assign keypad_edge_interrupt = row_event | knob_edge;
    assign key_valid             = key_valid_reg;

    kks_knob_decoder #(
        .ANGLE_WIDTH (ANGLE_WIDTH)
    ) u_knob (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .phase_a     (phase_a),
        .phase_b     (phase_b),
        .knob_edge   (knob_edge),
        .knob_cw_reg (knob_cw_reg),
        .angle_reg   (angle_reg)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            kks_pkg::ST_ARMED: begin
                if (row_event) begin
                    state_next = kks_pkg::ST_DRIVE;
                end
            end
            kks_pkg::ST_DRIVE: begin
                if (settled) begin
                    state_next = kks_pkg::ST_PROBE;
                end
            end
            kks_pkg::ST_PROBE: begin
                // Column sensed, or last column probed with none found: go to ST_REPORT, then re-arm
                if (col_hit || last_col) begin
                    state_next = kks_pkg::ST_REPORT;
                end
            end
            kks_pkg::ST_REPORT: begin
                state_next = kks_pkg::ST_ARMED;
            end
            default: begin
                state_next = kks_pkg::ST_ARMED;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= kks_pkg::ST_ARMED;
            row_prev_reg  <= '0;
            row_sel_reg   <= kks_pkg::KEY_NONE;
            col_idx_reg   <= 2'h0;
            settle_reg    <= 4'h0;
            key_valid_reg <= 1'b0;
            key_row_reg   <= kks_pkg::KEY_NONE;
            key_col_reg   <= kks_pkg::KEY_NONE;
        end else begin
            state_reg     <= state_next;
            row_prev_reg  <= armed ? row_in : '1;
            key_valid_reg <= 1'b0;
            if (row_event) begin
                row_sel_reg <= first_row;
                settle_reg  <= 4'h0;
                col_idx_reg <= 2'h0;
            end
            if (state_reg == kks_pkg::ST_DRIVE) begin
                settle_reg <= settle_reg + 4'h1;
            end
            if (state_reg == kks_pkg::ST_PROBE && !col_hit && !last_col) begin
                col_idx_reg <= col_idx_reg + 2'h1;
            end
            if (state_reg == kks_pkg::ST_PROBE && col_hit) begin
                key_row_reg   <= row_sel_reg;
                key_col_reg   <= col_idx_reg;
                key_valid_reg <= 1'b1;
            end
            if (state_reg == kks_pkg::ST_REPORT) begin
                row_sel_reg <= kks_pkg::KEY_NONE;
            end
        end
    end

    chk_single_row_drive: assert property (@(posedge ref_clk) disable iff (rst)
        $onehot0(row_oe))
        else $error("more than one row driven");
    chk_row_after_irq: assert property (@(posedge ref_clk) disable iff (rst)
        row_event |=> row_oe[row_sel_reg] && row_oe == (3'h1 << $past(first_row)))
        else $error("interrupting row not driven");
    chk_irq_rearm: assert property (@(posedge ref_clk) disable iff (rst)
        key_valid |=> armed)
        else $error("interrupt not re-armed after report");
    chk_scan_bound: assert property (@(posedge ref_clk) disable iff (rst)
        row_event |-> ##[1:12] armed)
        else $error("scan did not finish");
    chk_key_is_hit: assert property (@(posedge ref_clk) disable iff (rst)
        key_valid |-> key_col_reg == $past(col_idx_reg) && $past(col_hit))
        else $error("reported column not sensed");
    // Scan phase decodes used only by the checks below
    wire                  probing   = (state_reg == kks_pkg::ST_PROBE);
    wire                  reporting = (state_reg == kks_pkg::ST_REPORT);

    chk_press_irq: assert property (@(posedge ref_clk) disable iff (rst)
        (armed && $past(armed) && |(row_in & ~$past(row_in))) |-> keypad_edge_interrupt)
        else $error("press raised no interrupt");
    chk_no_irq_busy: assert property (@(posedge ref_clk) disable iff (rst)
        (!armed && !knob_edge) |-> !keypad_edge_interrupt)
        else $error("interrupt raised while scanning");
    chk_one_row_scan: assert property (@(posedge ref_clk) disable iff (rst)
        !armed |-> col_oe == '0 && $onehot(row_oe))
        else $error("scan lines not in scan shape");
    chk_probe_walk: assert property (@(posedge ref_clk) disable iff (rst)
        (probing && !col_hit && !last_col) |=> col_idx_reg == $past(col_idx_reg) + 2'h1)
        else $error("column probe did not advance by one");
    // Delay is the default settle count plus the cycle into ST_DRIVE
    chk_drive_settle: assert property (@(posedge ref_clk) disable iff (rst)
        row_event |-> ##5 (probing && col_idx_reg == 2'h0))
        else $error("probe did not start after settle");
    chk_key_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !key_valid |-> $stable(key_row_reg) && $stable(key_col_reg))
        else $error("key position moved without a report");
    chk_report_row: assert property (@(posedge ref_clk) disable iff (rst)
        key_valid |-> key_row_reg == $past(row_sel_reg))
        else $error("reported row not the driven row");
    chk_held_no_refind: assert property (@(posedge ref_clk) disable iff (rst)
        (armed && $past(reporting)) |-> !row_event)
        else $error("held key found again after re-arm");
    chk_miss_rearm: assert property (@(posedge ref_clk) disable iff (rst)
        (probing && last_col && !col_hit) |=> reporting && !key_valid)
        else $error("missed key not abandoned");
    chk_hit_reports: assert property (@(posedge ref_clk) disable iff (rst)
        (probing && col_hit) |=> key_valid && key_col_reg == $past(col_idx_reg))
        else $error("sensed column not reported");
    chk_col_index: assert property (@(posedge ref_clk) disable iff (rst)
        probing |-> col_idx_reg <= 2'(COL_COUNT - 1))
        else $error("probe column out of range");
    cov_key_held: cover property (@(posedge ref_clk) disable iff (rst)
        armed && $past(reporting) && |row_in);
    cov_key_found: cover property (@(posedge ref_clk) disable iff (rst) key_valid);
    cov_key_lost: cover property (@(posedge ref_clk) disable iff (rst)
        state_reg == kks_pkg::ST_PROBE && last_col && !col_hit);
endmodule // kks_scanner

// file: bench/kks_panel_model.sv
// Behavioural 3x3 key matrix and two-phase knob facing the scanner
module kks_panel_model (
    // Clock
    input  wire logic       ref_clk,
    // Scanner side
    input  wire logic [2:0] row_out,
    input  wire logic [2:0] row_oe,
    input  wire logic [2:0] col_out,
    input  wire logic [2:0] col_oe,
    output logic      [2:0] row_in,
    output logic      [2:0] col_in,
    output logic            phase_a,
    output logic            phase_b,
    // Bench control
    input  wire logic       key_down,
    input  wire logic [1:0] key_r,
    input  wire logic [1:0] key_c,
    input  wire logic       knob_step,
    input  wire logic       knob_dir
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos = 2'h0;
    logic [2:0] row_drv;
    logic [2:0] col_drv;
    assign row_drv = row_oe & row_out;
    assign col_drv = col_oe & col_out;
    // Undriven lines fall to the external pull-downs
    always_comb begin
        row_in = row_drv;
        col_in = col_drv;
        if (key_down) begin
            row_in[key_r] = row_drv[key_r] | col_drv[key_c];
            col_in[key_c] = col_drv[key_c] | row_drv[key_r];
        end
    end
    // Clockwise walk 00, 10, 11, 01
    always @(posedge ref_clk) begin
        if (knob_step) pos <= knob_dir ? pos + 2'h1 : pos - 2'h1;
    end
    assign phase_a = pos[1] ^ pos[0];
    assign phase_b = pos[1];
endmodule // kks_panel_model

// file: bench/tb.sv
// Self-checking bench for the keypad and knob scanner
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               ref_clk = 1'b0;
    logic               rst = 1'b1;
    logic        [2:0]  row_in, row_out, row_oe, col_in, col_out, col_oe;
    logic               phase_a, phase_b, irq, key_valid, knob_cw_reg;
    logic        [1:0]  key_row_reg, key_col_reg;
    logic signed [15:0] angle_reg;
    logic signed [15:0] exp_angle = 16'sh0;
    logic               key_down = 1'b0;
    logic        [1:0]  key_r = 2'h0;
    logic        [1:0]  key_c = 2'h0;
    logic               knob_step = 1'b0;
    logic               knob_dir = 1'b0;
    int                 n_errors = 0;
    int                 checks_done = 0;
    int                 n_found = 0;

    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (key_valid === 1'b1) n_found++;

    kks_scanner kks_scanner_inst (.ref_clk(ref_clk), .rst(rst), .row_in(row_in), .row_out(row_out),
        .row_oe(row_oe), .col_in(col_in), .col_out(col_out), .col_oe(col_oe), .phase_a(phase_a),
        .phase_b(phase_b), .keypad_edge_interrupt(irq), .key_valid(key_valid), .key_row_reg(key_row_reg),
        .key_col_reg(key_col_reg), .knob_cw_reg(knob_cw_reg), .angle_reg(angle_reg));
    kks_panel_model kks_panel_model_inst (.ref_clk(ref_clk), .row_out(row_out), .row_oe(row_oe),
        .col_out(col_out), .col_oe(col_oe), .row_in(row_in), .col_in(col_in), .phase_a(phase_a),
        .phase_b(phase_b), .key_down(key_down), .key_r(key_r), .key_c(key_c), .knob_step(knob_step),
        .knob_dir(knob_dir));

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        checks_done++;
        if (seen !== expd) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask

    function automatic logic signed [15:0] next_angle(input logic signed [15:0] a, input logic cw);
        return cw ? a + 16'sh1 : a - 16'sh1;
    endfunction

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Press, wait for the find, hold to prove no refind, then release
    task automatic press(input logic [1:0] r, input logic [1:0] c);
        int seen0;
        int w;
        seen0 = n_found;
        w = 0;
        key_r = r;
        key_c = c;
        key_down = 1'b1;
        #1 check(irq, 1'b1);
        @(posedge ref_clk);
        #1 check(row_oe, 3'h1 << r);
        while (n_found == seen0 && w < 12) begin
            @(posedge ref_clk);
            #1 w++;
        end
        check(n_found, seen0 + 1);
        check(key_row_reg, r);
        check(key_col_reg, c);
        check(col_oe, 3'h7);
        repeat (12) @(posedge ref_clk);
        #1 check(n_found, seen0 + 1);
        key_down = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic turn(input logic dir);
        knob_dir = dir;
        knob_step = 1'b1;
        @(posedge ref_clk);
        #1 knob_step = 1'b0;
        check(irq, 1'b1);
        exp_angle = next_angle(exp_angle, dir);
        @(posedge ref_clk);
        #1 check(knob_cw_reg, dir);
        check(angle_reg, exp_angle);
    endtask

    initial begin
        #20000;
        n_errors++;
        conclude;
    end

    initial begin
        void'($urandom(71));
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        check(key_row_reg, 2'h3);
        check(angle_reg, 32'h0);
        check(row_oe, 3'h0);
        check(col_oe, 3'h7);
        check(row_out, 3'h7);
        check(col_out, 3'h7);
        $display("test reset done");
        for (int i = 0; i < 9; i++) press(2'(i / 3), 2'(i % 3));
        repeat (6) press(2'($urandom % 3), 2'($urandom % 3));
        // Key let go before the probe: no column seen, scan gives up
        key_r = 2'h1;
        key_c = 2'h2;
        key_down = 1'b1;
        @(posedge ref_clk);
        #1 key_down = 1'b0;
        check(row_oe, 3'h2);
        repeat (10) @(posedge ref_clk);
        #1 check(n_found, 15);
        check(col_oe, 3'h7);
        $display("test lost key done");
        $display("test keys done");
        for (int i = 0; i < 24; i++) turn(1'($urandom % 2));
        // Back-to-back edges, one per cycle
        knob_dir = 1'b1;
        knob_step = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 knob_step = 1'b0;
        repeat (5) exp_angle = next_angle(exp_angle, 1'b1);
        @(posedge ref_clk);
        #1 check(angle_reg, exp_angle);
        $display("test knob done");
        conclude;
    end
endmodule // tb
